// ---- pkg/qcm_consts.vh ----
// Purpose: constants for the four-wire command mode flash host controller
// Assumes: included by its bare name
// Notes: opcodes, limits, security register addressing, register offsets
`ifndef QCM_CONSTS_VH
`define QCM_CONSTS_VH
// =====================================================
// opcodes
`define QCM_OP_WREN 8'h06
`define QCM_OP_VWREN 8'h50
`define QCM_OP_WRDIS 8'h04
`define QCM_OP_RDSR1 8'h05
`define QCM_OP_RDSR2 8'h35
`define QCM_OP_RDSR3 8'h15
`define QCM_OP_WRSR1 8'h01
`define QCM_OP_WRSR2 8'h31
`define QCM_OP_WRSR3 8'h11
`define QCM_OP_CE1 8'hC7
`define QCM_OP_CE2 8'h60
`define QCM_OP_SUSP 8'h75
`define QCM_OP_RESM 8'h7A
`define QCM_OP_PDN 8'hB9
`define QCM_OP_RPAR 8'hC0
`define QCM_OP_RELID 8'hAB
`define QCM_OP_MFID 8'h90
`define QCM_OP_JID 8'h9F
`define QCM_OP_EXIT 8'hFF
`define QCM_OP_PP 8'h02
`define QCM_OP_SE 8'h20
`define QCM_OP_BE32 8'h52
`define QCM_OP_BE64 8'hD8
`define QCM_OP_FRD 8'h0B
`define QCM_OP_WRAP 8'h0C
`define QCM_OP_QIO 8'hEB
`define QCM_OP_BLK 8'h36
`define QCM_OP_BUNL 8'h39
`define QCM_OP_BLRD 8'h3D
`define QCM_OP_SRPG 8'h42
`define QCM_OP_SRER 8'h44
// =====================================================
// limits and security register addressing
`define QCM_PAGE_MAX 9'h100
`define QCM_SEC_HI 8'h00
`define QCM_SEC1_MID 8'h10
`define QCM_SEC2_MID 8'h20
`define QCM_SEC3_MID 8'h30
`define QCM_MFID_PAD 8'h00
// =====================================================
// software register offsets
`define QCM_REG_CTRL 4'h0
`define QCM_REG_ADDR 4'h1
`define QCM_REG_TXD 4'h2
`define QCM_REG_RXD 4'h3
`define QCM_REG_STAT 4'h4
`define QCM_REG_PARAM 4'h5
// ctrl fields: [7:0] opcode, [15:8] dummy/pad bytes,
// [24:16] data bytes, [25] start, [26] read, [27] has address
`define QCM_CTRL_START 25
`define QCM_CTRL_READ 26
`define QCM_CTRL_ADDR 27
`define QCM_PARAM_RST 8'h00
`endif

// ---- logic/qcm_host.v ----
// Purpose: host controller driving a serial flash in four-wire command mode
// Assumes: link clock derived here by dividing sys_clk_i; device samples on rising sclk
// Notes: one frame per ctrl write; data bytes stream through txd/rxd registers
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "qcm_consts.vh"

// Overview of operation
// - opcode, address and data sent as two nibbles, upper nibble first.
// - every byte travels most significant bit first.
// - 90h sends two dummies and 00h; 9Fh returns three bytes.
// - 0Bh and 0Ch send three address bytes, dummies, then read data.
// - EBh sends address, mode byte, then remaining dummies before data.
// - program, erases, block lock/unlock and lock read take three address bytes.
// - host sends one to 256 program data bytes per program instruction.
// - word reads need aligned low address bits, supplied by software.
// - software issues write enable before program, erase or status write.
// - write enable framed by chip select, rising edge sampled opcode.
module qcm_host #(
    parameter DIV = 4
) (
    input wire sys_clk_i,
    input wire nrst_i,
    input wire [3:0] addr_i,
    input wire [31:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [31:0] rdata_o,
    output reg sclk_o,
    output reg ncs_o,
    output reg [3:0] io_o,
    output reg [3:0] io_oe_o,
    input wire [3:0] io_i
);
    localparam S_IDLE = 3'd0;
    localparam S_CMD = 3'd1;
    localparam S_ADR = 3'd2;
    localparam S_PAD = 3'd3;
    localparam S_DAT = 3'd4;
    localparam S_END = 3'd5;

    // =====================================================
    // input synchroniser
    reg [3:0] io_s1_ff;
    reg [3:0] io_s2_ff;
    always @(posedge sys_clk_i)
    begin
        io_s1_ff <= io_i;
        io_s2_ff <= io_s1_ff;
    end

    // =====================================================
    // software registers
    reg [7:0] op_ff;
    reg [7:0] pad_ff;
    reg [8:0] cnt_ff;
    reg rdop_ff;
    reg hasad_ff;
    reg [23:0] adr_ff;
    reg [7:0] txd_ff;
    reg txv_ff;
    reg [7:0] rxd_ff;
    reg rxv_ff;
    reg [7:0] param_ff;
    reg [2:0] st_ff;
    reg [7:0] sh_ff;
    reg [1:0] nib_ff;
    reg [7:0] dv_ff;
    reg [3:0] pdum_ff;
    reg [7:0] div_ff;
    reg phase_ff;
    wire busy = (st_ff != S_IDLE);
    wire tick = (div_ff == DIV[7:0] - 8'h01);
    wire rise = tick & ~phase_ff & ~ncs_o;
    wire fall = tick & phase_ff;
    wire fastrd = (op_ff == `QCM_OP_FRD) | (op_ff == `QCM_OP_WRAP);
    wire prog = (op_ff == `QCM_OP_PP) | (op_ff == `QCM_OP_SRPG);
    // stall on a full rx holder, or before a tx byte whose successor is missing;
    // the last byte never waits, so a short write cannot hang
    wire stall = (st_ff == S_DAT) & (nib_ff == 2'd0) & ~phase_ff
        & (rdop_ff ? rxv_ff : (~txv_ff & (cnt_ff > 9'h001)));

    always @(posedge sys_clk_i)
    begin
        if (!nrst_i)
            rdata_o <= 32'h0000_0000;
        else if (rd_i)
        begin
            case (addr_i)
                `QCM_REG_ADDR: rdata_o <= {8'h00, adr_ff};
                `QCM_REG_RXD: rdata_o <= {24'h0000_00, rxd_ff};
                `QCM_REG_STAT: rdata_o <= {24'h0000_00, 5'h00, txv_ff, rxv_ff, busy};
                `QCM_REG_PARAM: rdata_o <= {24'h0000_00, param_ff};
                `QCM_REG_CTRL: rdata_o <= {4'h0, hasad_ff, rdop_ff, 1'b0, cnt_ff,
                    pad_ff, op_ff};
                default: rdata_o <= 32'h0000_0000;
            endcase
        end
        else
            rdata_o <= 32'h0000_0000;
    end

    // =====================================================
    // clock divider and frame engine
    always @(posedge sys_clk_i)
    begin
        if (!nrst_i)
        begin
            op_ff <= 8'h00;
            pad_ff <= 8'h00;
            cnt_ff <= 9'h000;
            rdop_ff <= 1'b0;
            hasad_ff <= 1'b0;
            adr_ff <= 24'h0000_00;
            txd_ff <= 8'h00;
            txv_ff <= 1'b0;
            rxd_ff <= 8'h00;
            rxv_ff <= 1'b0;
            param_ff <= `QCM_PARAM_RST;
            st_ff <= S_IDLE;
            sh_ff <= 8'h00;
            nib_ff <= 2'd0;
            dv_ff <= 8'h00;
            pdum_ff <= 4'h0;
            div_ff <= 8'h00;
            phase_ff <= 1'b0;
            sclk_o <= 1'b0;
            ncs_o <= 1'b1;
            io_o <= 4'h0;
            io_oe_o <= 4'h0;
        end
        else
        begin
            if (rd_i && addr_i == `QCM_REG_RXD)
                rxv_ff <= 1'b0;
            if (wr_i && addr_i == `QCM_REG_TXD)
                txd_ff <= wdata_i[7:0];
            if (wr_i && addr_i == `QCM_REG_ADDR && !busy)
                adr_ff <= wdata_i[23:0]; // word-read alignment is software's
            if (wr_i && addr_i == `QCM_REG_CTRL && !busy && wdata_i[`QCM_CTRL_START])
            begin
                op_ff <= wdata_i[7:0];
                pad_ff <= wdata_i[15:8];
                rdop_ff <= wdata_i[`QCM_CTRL_READ];
                hasad_ff <= wdata_i[`QCM_CTRL_ADDR];
                // program data limited to 1..256 bytes
                if ((wdata_i[7:0] == `QCM_OP_PP || wdata_i[7:0] == `QCM_OP_SRPG)
                    && (wdata_i[24:16] == 9'h000 || wdata_i[24:16] > `QCM_PAGE_MAX))
                    cnt_ff <= `QCM_PAGE_MAX;
                else
                    cnt_ff <= wdata_i[24:16];
                // every frame opens with chip select low
                ncs_o <= 1'b0;
                st_ff <= S_CMD;
                sh_ff <= wdata_i[7:0];
                nib_ff <= 2'd0;
                div_ff <= 8'h00;
                phase_ff <= 1'b0;
                io_o <= wdata_i[7:4];
                io_oe_o <= 4'hF;
            end
            else if (busy && !stall)
            begin
                div_ff <= tick ? 8'h00 : div_ff + 8'h01;
                if (tick && st_ff != S_END)
                begin
                    phase_ff <= ~phase_ff;
                    sclk_o <= ~phase_ff;
                end
                if (rise && rdop_ff && st_ff == S_DAT)
                    sh_ff <= {sh_ff[3:0], io_s2_ff};
                if (fall)
                begin
                    if (nib_ff == 2'd0)
                    begin
                        nib_ff <= 2'd1;
                        io_o <= sh_ff[3:0]; // lower nibble second
                    end
                    else
                    begin
                        nib_ff <= 2'd0;
                        case (st_ff)
                            S_CMD:
                            begin
                                // setup for the next phase after opcode
                                if (hasad_ff)
                                begin
                                    st_ff <= S_ADR;
                                    dv_ff <= 8'd2;
                                    sh_ff <= adr_ff[23:16];
                                    io_o <= adr_ff[23:20];
                                end
                                else if (pad_ff != 8'h00)
                                begin
                                    st_ff <= S_PAD;
                                    dv_ff <= pad_ff;
                                    sh_ff <= (op_ff == `QCM_OP_MFID && pad_ff == 8'd1)
                                        ? `QCM_MFID_PAD : 8'h00;
                                    io_o <= 4'h0;
                                end
                                else if (cnt_ff != 9'h000 || rdop_ff)
                                begin
                                    st_ff <= S_DAT;
                                    if (rdop_ff)
                                        io_oe_o <= 4'h0;
                                    else
                                    begin
                                        sh_ff <= txd_ff;
                                        io_o <= txd_ff[7:4];
                                        txv_ff <= 1'b0;
                                    end
                                end
                                else
                                    st_ff <= S_END;
                            end
                            S_ADR:
                            begin
                                if (dv_ff != 8'h00)
                                begin
                                    dv_ff <= dv_ff - 8'h01;
                                    sh_ff <= (dv_ff == 8'd2) ? adr_ff[15:8] : adr_ff[7:0];
                                    io_o <= (dv_ff == 8'd2) ? adr_ff[15:12] : adr_ff[7:4];
                                end
                                else if (op_ff == `QCM_OP_QIO || pad_ff != 8'h00)
                                begin
                                    // EBh: mode byte first, then parameter dummies
                                    st_ff <= S_PAD;
                                    dv_ff <= (op_ff == `QCM_OP_QIO) ? 8'd1 : pad_ff;
                                    pdum_ff <= param_ff[7:4];
                                    sh_ff <= 8'h00;
                                    io_o <= 4'h0;
                                end
                                else if (fastrd)
                                begin
                                    st_ff <= S_PAD; // dummy clocks from parameters
                                    dv_ff <= 8'h00;
                                    pdum_ff <= param_ff[7:4];
                                    io_oe_o <= 4'h0;
                                end
                                else if (cnt_ff != 9'h000 || rdop_ff)
                                begin
                                    st_ff <= S_DAT;
                                    if (rdop_ff)
                                        io_oe_o <= 4'h0;
                                    else
                                    begin
                                        sh_ff <= txd_ff;
                                        io_o <= txd_ff[7:4];
                                        txv_ff <= 1'b0;
                                    end
                                end
                                else
                                    st_ff <= S_END;
                            end
                            S_PAD:
                            begin
                                if (dv_ff > 8'd1)
                                begin
                                    dv_ff <= dv_ff - 8'h01;
                                    sh_ff <= (op_ff == `QCM_OP_MFID && dv_ff == 8'd2)
                                        ? `QCM_MFID_PAD : 8'h00;
                                    io_o <= 4'h0;
                                end
                                else if ((fastrd || op_ff == `QCM_OP_QIO) && pdum_ff > 4'd2)
                                begin
                                    // byte-wise stepping of parameter dummy clocks
                                    dv_ff <= 8'h00;
                                    pdum_ff <= pdum_ff - 4'd2;
                                    io_oe_o <= 4'h0;
                                end
                                else
                                begin
                                    st_ff <= S_DAT;
                                    if (rdop_ff)
                                        io_oe_o <= 4'h0;
                                    else
                                    begin
                                        sh_ff <= txd_ff;
                                        io_o <= txd_ff[7:4];
                                        txv_ff <= 1'b0;
                                    end
                                end
                            end
                            S_DAT:
                            begin
                                if (rdop_ff)
                                begin
                                    rxd_ff <= sh_ff; // count 0 streams on
                                    rxv_ff <= 1'b1;
                                    if (cnt_ff == 9'h001)
                                        st_ff <= S_END;
                                    if (cnt_ff != 9'h000)
                                        cnt_ff <= cnt_ff - 9'h001;
                                end
                                else if (cnt_ff <= 9'h001)
                                    st_ff <= S_END;
                                else
                                begin
                                    cnt_ff <= cnt_ff - 9'h001;
                                    sh_ff <= txd_ff;
                                    io_o <= txd_ff[7:4];
                                    txv_ff <= 1'b0;
                                end
                            end
                            default: st_ff <= S_END;
                        endcase
                    end
                end
                if (st_ff == S_END && tick)
                begin
                    // release chip select, ends repeating reads
                    ncs_o <= 1'b1;
                    io_oe_o <= 4'h0;
                    sclk_o <= 1'b0;
                    st_ff <= S_IDLE;
                end
            end
            // software may end a streaming read by writing ctrl with start low
            if (wr_i && addr_i == `QCM_REG_CTRL && busy && !wdata_i[`QCM_CTRL_START])
                st_ff <= S_END;
            if (wr_i && addr_i == `QCM_REG_PARAM)
                param_ff <= wdata_i[7:0]; // mirror of the byte sent with C0h
            // last, so a fresh byte outranks the engine consuming the old one
            if (wr_i && addr_i == `QCM_REG_TXD)
                txv_ff <= 1'b1;
        end
    end
endmodule // qcm_host
`default_nettype wire

// ---- test/qcm_host_props.sv ----
// Purpose: port checker for the four-wire command mode host
// Assumes: synchronous active-low reset, ctrl layout of the consts header
// Notes: bound onto every host instance
`timescale 1ns/100ps
`default_nettype none
`include "qcm_consts.vh"
module qcm_host_props #(
    parameter int DIV = 4
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic sclk_o,
    input wire logic ncs_o,
    input wire logic [3:0] io_o,
    input wire logic [3:0] io_oe_o,
    input wire logic [3:0] io_i
);
    // =====================================================
    // helper: length of the current high phase of sclk
    logic [7:0] hi_cnt_ff;
    always_ff @(posedge sys_clk_i)
        hi_cnt_ff <= (!nrst_i || !sclk_o) ? 8'h00 : hi_cnt_ff + 8'h01;
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!nrst_i);
    // =====================================================
    // properties
    a_reset_idle: assert property (@(posedge sys_clk_i) disable iff (1'b0)
        !nrst_i |=> ncs_o && !sclk_o && io_oe_o == 4'h0 && rdata_o == 32'h0000_0000)
        else $error("outputs not idle after reset");
    a_idle_clock: assert property (ncs_o |-> !sclk_o)
        else $error("sclk high while deselected");
    a_frame_start: assert property (wr_i && addr_i == `QCM_REG_CTRL && ncs_o
        && wdata_i[`QCM_CTRL_START] && $past(ncs_o, 4)
        |=> !ncs_o && io_oe_o == 4'hF && io_o == $past(wdata_i[7:4]))
        else $error("frame did not open with upper opcode nibble");
    a_sclk_high: assert property ($fell(sclk_o) |-> hi_cnt_ff == DIV)
        else $error("sclk high phase has wrong length");
    a_io_hold: assert property (sclk_o && $past(sclk_o)
        |-> $stable(io_o) && $stable(io_oe_o))
        else $error("quad lines moved while sclk high");
    a_cs_edge: assert property ($changed(ncs_o) |-> !sclk_o)
        else $error("chip select moved while sclk high");
    a_oe_release: assert property (ncs_o && $past(ncs_o) |-> io_oe_o == 4'h0)
        else $error("quad lines driven outside a frame");
    a_busy_flag: assert property (rd_i && addr_i == `QCM_REG_STAT && !ncs_o
        |=> rdata_o[0])
        else $error("busy clear while chip select low");
endmodule // qcm_host_props
bind qcm_host qcm_host_props #(.DIV(DIV)) props_u (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sclk_o(sclk_o), .ncs_o(ncs_o),
    .io_o(io_o), .io_oe_o(io_oe_o), .io_i(io_i));
`default_nettype wire

// ---- test/qcm_flash_model.sv ----
// Purpose: behavioural flash on the far side of the quad lines
// Assumes: samples the host's sclk with the system clock
// Notes: records every byte the host drives; replies on falling sclk
`timescale 1ns/100ps
`default_nettype none
`include "qcm_consts.vh"
module qcm_flash_model #(
    parameter logic [7:0] SR1_V = 8'h00,
    parameter logic [7:0] SR2_V = 8'h00,
    parameter logic [7:0] SR3_V = 8'h00,
    parameter logic [7:0] MAKER_V = 8'h00,
    parameter logic [7:0] LOCK_V = 8'h00,
    parameter logic [15:0] PART_V = 16'h0000
) (
    input wire logic sys_clk_i,
    input wire logic sclk_i,
    input wire logic ncs_n_i,
    input wire logic [3:0] io_i,
    input wire logic [3:0] io_oe_i,
    output logic [3:0] io_o = 4'h0
);
    logic [7:0] got_q[$];
    logic [7:0] op_ff = 8'h00;
    logic [7:0] rb;
    logic [3:0] hi_ff = 4'h0;
    logic sclk_ff = 1'b0, ncs_ff = 1'b1, half_ff = 1'b0, write_latch_flag = 1'b0;
    int nib = 0, fb = 0;
    // =====================================================
    // reply bytes; bare and parameter opcodes get none
    function automatic logic [7:0] reply(input int i);
        case (op_ff)
            `QCM_OP_RDSR1: return SR1_V;
            `QCM_OP_RDSR2: return SR2_V;
            `QCM_OP_RDSR3: return SR3_V;
            `QCM_OP_RELID: return PART_V[7:0];
            `QCM_OP_MFID: return i[0] ? PART_V[7:0] : MAKER_V;
            `QCM_OP_JID: return (i % 3 == 0) ? MAKER_V : ((i % 3 == 1) ? PART_V[15:8] : PART_V[7:0]);
            `QCM_OP_BLRD: return LOCK_V;
            default: return 8'h00;
        endcase
    endfunction
    // =====================================================
    // link side
    always @(posedge sys_clk_i)
    begin
        sclk_ff <= sclk_i;
        ncs_ff <= ncs_n_i;
        if (ncs_n_i)
        begin
            half_ff <= 1'b0;
            nib <= 0;
            fb <= 0;
            io_o <= ~io_o; // undriven lines must not hold the last value
            if (!ncs_ff && fb > 0)
                case (op_ff)
                    `QCM_OP_WREN: write_latch_flag <= 1'b1;
                    `QCM_OP_WRDIS: write_latch_flag <= 1'b0;
                    `QCM_OP_VWREN: write_latch_flag <= write_latch_flag;
                    `QCM_OP_PP, `QCM_OP_SE, `QCM_OP_BE32, `QCM_OP_BE64, `QCM_OP_CE1,
                    `QCM_OP_CE2, `QCM_OP_WRSR1, `QCM_OP_WRSR2, `QCM_OP_WRSR3, `QCM_OP_SRPG,
                    `QCM_OP_SRER: write_latch_flag <= 1'b0;
                    default: write_latch_flag <= write_latch_flag;
                endcase
        end
        else if (sclk_i && !sclk_ff && io_oe_i == 4'hF)
        begin
            if (half_ff && fb == 0)
                op_ff <= {hi_ff, io_i};
            if (half_ff)
                got_q.push_back({hi_ff, io_i});
            fb <= fb + (half_ff ? 1 : 0);
            hi_ff <= io_i;
            half_ff <= ~half_ff;
        end
        else if (!sclk_i && sclk_ff && io_oe_i == 4'h0)
        begin
            rb = reply(nib / 2);
            io_o <= nib[0] ? rb[3:0] : rb[7:4];
            nib <= nib + 1;
        end
        else if (io_oe_i != 4'h0)
            io_o <= ~io_o;
    end
endmodule // qcm_flash_model
`default_nettype wire

// ---- test/qcm_host_tb.sv ----
// Purpose: self-checking bench for the quad command host
// Assumes: software register map and ctrl layout of the consts header
// Notes: wire bytes are checked through the flash model's capture queue
`timescale 1ns/100ps
`default_nettype none
`include "qcm_consts.vh"
module qcm_host_tb;
    // identity values are arbitrary
    localparam logic [7:0] MAKER_V = 8'h3C;
    localparam logic [15:0] PART_V = 16'h51A7;
    localparam logic [7:0] BARE [9] = '{`QCM_OP_WREN, `QCM_OP_VWREN, `QCM_OP_WRDIS,
        `QCM_OP_CE1, `QCM_OP_CE2, `QCM_OP_SUSP, `QCM_OP_RESM, `QCM_OP_PDN, `QCM_OP_EXIT};
    localparam logic [7:0] ADDR_OPS [5] = '{`QCM_OP_SE, `QCM_OP_BE32, `QCM_OP_BE64,
        `QCM_OP_BLK, `QCM_OP_BUNL};
    localparam logic [7:0] SR_OPS [3] = '{`QCM_OP_RDSR1, `QCM_OP_RDSR2, `QCM_OP_RDSR3};
    logic sys_clk_i = 1'b0, nrst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [31:0] wdata_i = 32'h0000_0000;
    wire [31:0] rdata_o;
    wire sclk_o, ncs_o;
    wire [3:0] io_o, io_oe_o, dev_io, io_w;
    int miscompares = 0, tests_run = 0, cyc = 0;
    logic [7:0] exp_q[$];
    logic [7:0] pad_v = 8'h00;
    assign io_w = (io_oe_o & io_o) | (~io_oe_o & dev_io);
    always #50 sys_clk_i = ~sys_clk_i;
    qcm_host #(.DIV(4)) dut_u (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sclk_o(sclk_o),
        .ncs_o(ncs_o), .io_o(io_o), .io_oe_o(io_oe_o), .io_i(io_w));
    qcm_flash_model #(.SR1_V(8'hA5), .SR2_V(8'h02), .SR3_V(8'h60), .MAKER_V(MAKER_V),
        .LOCK_V(8'h01), .PART_V(PART_V)) fm_u (.sys_clk_i(sys_clk_i), .sclk_i(sclk_o),
        .ncs_n_i(ncs_o), .io_i(io_w), .io_oe_i(io_oe_o), .io_o(dev_io));
    // =====================================================
    // tasks
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask
    // bounded wait on one status bit
    task automatic poll(input int b, input logic val);
        logic [31:0] v;
        int k;
        k = 0;
        do
        begin
            rd(`QCM_REG_STAT, v);
            k++;
        end while (v[b] !== val && k < 3000);
        chk("stat_bit", {31'h0, val}, {31'h0, v[b]});
    endtask
    // one frame: opcode, optional address, tx data or rx bytes
    task automatic run(input logic [7:0] op, input logic ha, input logic rdf,
        input logic [23:0] ad, input logic [8:0] n, input int nd);
        logic [31:0] v;
        logic [7:0] dq[$];
        if (op inside {`QCM_OP_PP, `QCM_OP_SE, `QCM_OP_BE32, `QCM_OP_BE64, `QCM_OP_CE1,
            `QCM_OP_CE2, `QCM_OP_WRSR1, `QCM_OP_WRSR2, `QCM_OP_WRSR3, `QCM_OP_SRPG,
            `QCM_OP_SRER})
            chk("write_latch", 32'h1, {31'h0, fm_u.write_latch_flag});
        exp_q = {op};
        if (ha)
            exp_q = {exp_q, ad[23:16], ad[15:8], ad[7:0]};
        repeat (pad_v)
            exp_q.push_back(8'h00); // dummies go out as zeros
        for (int i = 0; i < nd; i++)
            dq.push_back(8'($urandom));
        exp_q = {exp_q, dq};
        fm_u.got_q.delete();
        wr(`QCM_REG_ADDR, {8'h00, ad});
        if (nd > 0)
            wr(`QCM_REG_TXD, {24'h00_0000, dq[0]});
        wr(`QCM_REG_CTRL, {4'h0, ha, rdf, 1'b1, n, pad_v, op});
        for (int i = 1; i < nd; i++)
        begin
            poll(2, 1'b0);
            wr(`QCM_REG_TXD, {24'h00_0000, dq[i]});
        end
        for (int i = 0; rdf && i < n; i++)
        begin
            poll(1, 1'b1);
            rd(`QCM_REG_RXD, v);
            chk("rxd", {24'h00_0000, fm_u.reply(i)}, {24'h00_0000, v[7:0]});
        end
        poll(0, 1'b0);
        chk("frame_len", 32'(exp_q.size()), 32'(fm_u.got_q.size()));
        foreach (exp_q[i])
            chk("wire_byte", {24'h00_0000, exp_q[i]}, {24'h00_0000, fm_u.got_q[i]});
        $display("test done opcode %h", op);
    endtask
    always @(posedge sys_clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            miscompares++;
            $display("ERROR run_time expected under 60000 seen 60000");
            end_sim;
        end
    end
    // =====================================================
    // main sequence
    initial
    begin
        void'($urandom(32'h82f6_d5d6));
        repeat (4) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        foreach (BARE[i])
        begin
            if (BARE[i] inside {`QCM_OP_CE1, `QCM_OP_CE2})
                run(`QCM_OP_WREN, 1'b0, 1'b0, 24'h00_0000, 9'h000, 0);
            run(BARE[i], 1'b0, 1'b0, 24'h00_0000, 9'h000, 0);
        end
        run(`QCM_OP_WREN, 1'b0, 1'b0, 24'h00_0000, 9'h000, 0);
        run(`QCM_OP_WRSR1, 1'b0, 1'b0, 24'h00_0000, 9'h001, 1);
        run(`QCM_OP_RPAR, 1'b0, 1'b0, 24'h00_0000, 9'h001, 1);
        foreach (SR_OPS[i])
            run(SR_OPS[i], 1'b0, 1'b1, 24'h00_0000, 9'h003, 0);
        run(`QCM_OP_JID, 1'b0, 1'b1, 24'h00_0000, 9'h003, 0);
        pad_v = 8'd3;
        run(`QCM_OP_RELID, 1'b0, 1'b1, 24'h00_0000, 9'h002, 0);
        run(`QCM_OP_MFID, 1'b0, 1'b1, 24'h00_0000, 9'h002, 0);
        pad_v = 8'd0;
        run(`QCM_OP_FRD, 1'b1, 1'b1, 24'($urandom), 9'h001, 0);
        pad_v = 8'd1;
        run(`QCM_OP_QIO, 1'b1, 1'b1, 24'($urandom) & 24'hFF_FFF0, 9'h001, 0);
        pad_v = 8'd0;
        run(`QCM_OP_BLRD, 1'b1, 1'b1, 24'($urandom), 9'h001, 0);
        foreach (ADDR_OPS[i])
        begin
            run(`QCM_OP_WREN, 1'b0, 1'b0, 24'h00_0000, 9'h000, 0);
            run(ADDR_OPS[i], 1'b1, 1'b0, 24'($urandom), 9'h000, 0);
        end
        run(`QCM_OP_WREN, 1'b0, 1'b0, 24'h00_0000, 9'h000, 0);
        run(`QCM_OP_SRER, 1'b1, 1'b0, {16'h0020, 8'($urandom)}, 9'h000, 0);
        run(`QCM_OP_WREN, 1'b0, 1'b0, 24'h00_0000, 9'h000, 0);
        run(`QCM_OP_PP, 1'b1, 1'b0, 24'($urandom), 9'h003, 3);
        run(`QCM_OP_WREN, 1'b0, 1'b0, 24'h00_0000, 9'h000, 0);
        run(`QCM_OP_PP, 1'b1, 1'b0, 24'($urandom), 9'h101, 256);
        run(`QCM_OP_WREN, 1'b0, 1'b0, 24'h00_0000, 9'h000, 0);
        run(`QCM_OP_SRPG, 1'b1, 1'b0, {16'h0030, 8'($urandom)}, 9'h002, 2);
        end_sim;
    end
endmodule // qcm_host_tb
`default_nettype wire
